/* File: port_mode_pkg.sv */
package port_mode_pkg;

    localparam int NUM_PORTS = 4;
    localparam int REG_WIDTH = 16;

    // management register address of the all-port mode control register
    localparam logic [4:0] MODE_CTRL_ADDR = 5'h13;
    localparam logic [15:0] MODE_CTRL_RESET = 16'h0000;

    // field positions, each field is one bit per port, port 3 in the msb
    localparam int SELF_RETURN_LSB = 12;
    localparam int SLEEP_LSB = 8;
    localparam int PIN_RELEASE_LSB = 4;
    localparam int FULL_TWO_WAY_LSB = 0;

    // management frame shape
    localparam int PREAMBLE_BITS = 32;
    localparam int HDR_BITS = 12;
    localparam int DATA_BITS = 16;
    localparam logic [1:0] OP_WRITE = 2'h1;
    localparam logic [1:0] OP_READ = 2'h2;

    typedef enum logic [2:0] {
        S_IDLE,
        S_START,
        S_HDR,
        S_TA1,
        S_TA2,
        S_DATA
    } mgmt_state_t;

endpackage

/* File: port_pin_gate.sv */
`timescale 1ns/1ps
module port_pin_gate (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_self_return,
    input wire logic i_sleep,
    input wire logic i_pin_release,
    input wire logic i_txd_pin,
    input wire logic i_txen_pin,
    input wire logic i_rxd_core,
    input wire logic i_rxclk_core,
    input wire logic i_col_core,
    output logic o_tx_d,
    output logic o_tx_en,
    output logic o_rxd,
    output logic o_rxd_oe,
    output logic o_rxclk,
    output logic o_rxclk_oe,
    output logic o_col,
    output logic o_col_oe
);
    logic txd_s1_r, txd_s2_r, txen_s1_r, txen_s2_r;
    logic tx_ok;

    // mac pins arrive from another domain
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            txd_s1_r <= 1'b0;
            txd_s2_r <= 1'b0;
            txen_s1_r <= 1'b0;
            txen_s2_r <= 1'b0;
        end else begin
            txd_s1_r <= i_txd_pin;
            txd_s2_r <= txd_s1_r;
            txen_s1_r <= i_txen_pin;
            txen_s2_r <= txen_s1_r;
        end
    end

    assign tx_ok = !i_sleep && !i_pin_release;

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_tx_d <= 1'b0;
            o_tx_en <= 1'b0;
        end else begin
            o_tx_en <= txen_s2_r && tx_ok;
            o_tx_d <= txd_s2_r && tx_ok;
        end
    end

    // in self-return the transmit stream is handed back as receive data
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_rxd <= 1'b0;
            o_rxclk <= 1'b0;
            o_col <= 1'b0;
        end else if (i_sleep) begin
            o_rxd <= 1'b0;
            o_rxclk <= 1'b0;
            o_col <= 1'b0;
        end else if (i_self_return) begin
            o_rxd <= txd_s2_r && txen_s2_r && !i_pin_release;
            o_rxclk <= i_rxclk_core;
            o_col <= 1'b0;
        end else begin
            o_rxd <= i_rxd_core;
            o_rxclk <= i_rxclk_core;
            o_col <= i_col_core;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_rxd_oe <= 1'b1;
            o_rxclk_oe <= 1'b1;
            o_col_oe <= 1'b1;
        end else begin
            o_rxd_oe <= !i_pin_release;
            o_rxclk_oe <= !i_pin_release;
            o_col_oe <= !i_pin_release;
        end
    end

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);

    a_release_pins_hiz: assert property (i_pin_release |=>
        !o_rxd_oe && !o_rxclk_oe && !o_col_oe)
        else $error("isolated port still drives its receive pins");
    a_release_tx_ignored: assert property (i_pin_release |=> !o_tx_en && !o_tx_d)
        else $error("isolated port passed transmit input");
    a_sleep_no_data: assert property (i_sleep |=> !o_tx_en && !o_rxd && !o_col)
        else $error("sleeping port moved data");
endmodule

/* File: port_mode_ctrl.sv */
// Summary of operation
// - bits 15..12 put ports into self-return
// - bits 11..8 hold ports in sleep
// - sleeping port neither transmits nor delivers data
// - bits 7..4 make port ignore transmit inputs
// - released port floats receive, clock, collision pins
// - released port still answers management frames
// - bits 3..0 force full two-way operation
// - cleared duplex bit forces half two-way
// - all four asleep: only reset recovers
// - while all asleep, clearing one bit fails
`timescale 1ns/1ps
module port_mode_ctrl
    import port_mode_pkg::*;
#(
    parameter logic [4:0] PORT_BASE_ADDR = 5'h00,
    parameter int PREAMBLE_LEN = PREAMBLE_BITS
) (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_mdc,
    input wire logic i_mdio,
    output logic o_mdio,
    output logic o_mdio_oe,
    input wire logic [NUM_PORTS-1:0] i_txd,
    input wire logic [NUM_PORTS-1:0] i_txen,
    input wire logic [NUM_PORTS-1:0] i_rxd_core,
    input wire logic [NUM_PORTS-1:0] i_rxclk_core,
    input wire logic [NUM_PORTS-1:0] i_col_core,
    output logic [NUM_PORTS-1:0] o_tx_d,
    output logic [NUM_PORTS-1:0] o_tx_en,
    output logic [NUM_PORTS-1:0] o_rxd,
    output logic [NUM_PORTS-1:0] o_rxd_oe,
    output logic [NUM_PORTS-1:0] o_rxclk,
    output logic [NUM_PORTS-1:0] o_rxclk_oe,
    output logic [NUM_PORTS-1:0] o_col,
    output logic [NUM_PORTS-1:0] o_col_oe,
    output logic [NUM_PORTS-1:0] o_self_return,
    output logic [NUM_PORTS-1:0] o_sleep,
    output logic [NUM_PORTS-1:0] o_pin_release,
    output logic [NUM_PORTS-1:0] o_full_two_way
);

    if (PORT_BASE_ADDR[1:0] != 2'h0) begin : g_bad_base
        $error("port base address must be a multiple of four");
    end
    if (PREAMBLE_LEN < 1 || PREAMBLE_LEN > 255) begin : g_bad_pre
        $error("preamble length out of range");
    end

    function automatic logic [NUM_PORTS-1:0] field4(input logic [REG_WIDTH-1:0] v,
                                                    input int lsb);
        field4 = v[lsb +: NUM_PORTS];
    endfunction

    // synchronisers for the management pins
    logic mdc_s1_r, mdc_s2_r, mdc_s3_r;
    logic mdio_s1_r, mdio_s2_r;
    logic rise;

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            mdc_s1_r <= 1'b0;
            mdc_s2_r <= 1'b0;
            mdc_s3_r <= 1'b0;
            mdio_s1_r <= 1'b1;
            mdio_s2_r <= 1'b1;
        end else begin
            mdc_s1_r <= i_mdc;
            mdc_s2_r <= mdc_s1_r;
            mdc_s3_r <= mdc_s2_r;
            mdio_s1_r <= i_mdio;
            mdio_s2_r <= mdio_s1_r;
        end
    end

    // data and clock go through equal depth, so the sample lines up with the edge
    assign rise = mdc_s2_r && !mdc_s3_r;

    mgmt_state_t state_r;
    logic [7:0] pre_cnt_r;
    logic [4:0] bit_cnt_r;
    logic [HDR_BITS-1:0] hdr_r;
    logic [DATA_BITS-1:0] wdata_r;
    logic [DATA_BITS-1:0] rdata_r;
    logic is_read_r;
    logic hit_r;
    logic [HDR_BITS-1:0] hdr_full;
    logic hdr_hit;
    logic wr_commit;
    logic [DATA_BITS-1:0] wr_value;
    logic [REG_WIDTH-1:0] ctrl_r;

    assign hdr_full = {hdr_r[HDR_BITS-2:0], mdio_s2_r};
    // any of the four port addresses reaches the shared register, isolated or not
    assign hdr_hit = (hdr_full[9:7] == PORT_BASE_ADDR[4:2])
                  && (hdr_full[4:0] == MODE_CTRL_ADDR);
    assign wr_value = {wdata_r[DATA_BITS-2:0], mdio_s2_r};
    assign wr_commit = rise && state_r == S_DATA && !is_read_r && hit_r
                    && bit_cnt_r == 5'(DATA_BITS - 1);

    // frame walker; a frame needs a full preamble, suppression is not supported
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            state_r <= S_IDLE;
            pre_cnt_r <= 8'h00;
            bit_cnt_r <= 5'h00;
            hdr_r <= '0;
            is_read_r <= 1'b0;
            hit_r <= 1'b0;
        end else if (rise) begin
            unique case (state_r)
                S_IDLE: begin
                    if (mdio_s2_r) begin
                        if (pre_cnt_r != 8'hFF) begin
                            pre_cnt_r <= pre_cnt_r + 8'h01;
                        end
                    end else begin
                        pre_cnt_r <= 8'h00;
                        if (pre_cnt_r >= 8'(PREAMBLE_LEN)) begin
                            state_r <= S_START;
                        end
                    end
                end
                S_START: begin
                    bit_cnt_r <= 5'h00;
                    state_r <= mdio_s2_r ? S_HDR : S_IDLE;
                end
                S_HDR: begin
                    hdr_r <= hdr_full;
                    bit_cnt_r <= bit_cnt_r + 5'h01;
                    if (bit_cnt_r == 5'(HDR_BITS - 1)) begin
                        is_read_r <= hdr_full[11:10] == OP_READ;
                        hit_r <= hdr_hit && (hdr_full[11:10] == OP_READ
                                          || hdr_full[11:10] == OP_WRITE);
                        state_r <= S_TA1;
                    end
                end
                S_TA1: begin
                    state_r <= S_TA2;
                end
                S_TA2: begin
                    bit_cnt_r <= 5'h00;
                    state_r <= S_DATA;
                end
                S_DATA: begin
                    bit_cnt_r <= bit_cnt_r + 5'h01;
                    if (bit_cnt_r == 5'(DATA_BITS - 1)) begin
                        state_r <= S_IDLE;
                    end
                end
                default: begin
                    state_r <= S_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            wdata_r <= '0;
        end else if (rise && state_r == S_DATA) begin
            wdata_r <= wr_value;
        end
    end

    // read answer: drive zero in the second turnaround bit, then data msb first
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_mdio <= 1'b1;
            o_mdio_oe <= 1'b0;
            rdata_r <= '0;
        end else if (rise) begin
            if (state_r == S_TA1 && is_read_r && hit_r) begin
                o_mdio_oe <= 1'b1;
                o_mdio <= 1'b0;
            end else if (state_r == S_TA2 && o_mdio_oe) begin
                rdata_r <= ctrl_r;
                o_mdio <= ctrl_r[REG_WIDTH-1];
            end else if (state_r == S_DATA && o_mdio_oe) begin
                if (bit_cnt_r == 5'(DATA_BITS - 1)) begin
                    o_mdio_oe <= 1'b0;
                    o_mdio <= 1'b1;
                end else begin
                    o_mdio <= rdata_r[REG_WIDTH-2];
                    rdata_r <= {rdata_r[REG_WIDTH-2:0], 1'b0};
                end
            end else if (state_r == S_IDLE) begin
                o_mdio_oe <= 1'b0;
                o_mdio <= 1'b1;
            end
        end
    end

    // every bit is stored as written, even while the sleep lock holds
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            ctrl_r <= MODE_CTRL_RESET;
        end else if (wr_commit) begin
            ctrl_r <= wr_value;
        end
    end

    // once every port sleeps the oscillators are gone; only reset wakes them
    logic all_down_r;

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            all_down_r <= 1'b0;
        end else if (field4(ctrl_r, SLEEP_LSB) == 4'hF) begin
            all_down_r <= 1'b1;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_self_return <= '0;
            o_sleep <= '0;
            o_pin_release <= '0;
            o_full_two_way <= '0;
        end else begin
            o_self_return <= field4(ctrl_r, SELF_RETURN_LSB);
            o_sleep <= all_down_r ? 4'hF : field4(ctrl_r, SLEEP_LSB);
            o_pin_release <= field4(ctrl_r, PIN_RELEASE_LSB);
            o_full_two_way <= field4(ctrl_r, FULL_TWO_WAY_LSB);
        end
    end

    for (genvar p = 0; p < NUM_PORTS; p++) begin : g_port
        port_pin_gate u_gate (
            .i_clk(i_clk),
            .i_rst(i_rst),
            .i_self_return(o_self_return[p]),
            .i_sleep(o_sleep[p]),
            .i_pin_release(o_pin_release[p]),
            .i_txd_pin(i_txd[p]),
            .i_txen_pin(i_txen[p]),
            .i_rxd_core(i_rxd_core[p]),
            .i_rxclk_core(i_rxclk_core[p]),
            .i_col_core(i_col_core[p]),
            .o_tx_d(o_tx_d[p]),
            .o_tx_en(o_tx_en[p]),
            .o_rxd(o_rxd[p]),
            .o_rxd_oe(o_rxd_oe[p]),
            .o_rxclk(o_rxclk[p]),
            .o_rxclk_oe(o_rxclk_oe[p]),
            .o_col(o_col[p]),
            .o_col_oe(o_col_oe[p])
        );
    end

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);

    sequence s_read_header;
        rise && state_r == S_TA1 && is_read_r && hit_r;
    endsequence
    sequence s_turnaround_zero;
        o_mdio_oe && !o_mdio;
    endsequence

    a_read_answer_drive: assert property (s_read_header |=> s_turnaround_zero)
        else $error("read of mode register not answered");
    a_write_store_value: assert property (wr_commit |=> ctrl_r == $past(wr_value))
        else $error("written value not stored");
    a_self_return_follow: assert property (wr_commit |-> ##2
        o_self_return == $past(wr_value[15:12], 2))
        else $error("self-return outputs do not follow write");
    a_full_two_way_set: assert property (wr_commit |-> ##2
        o_full_two_way == $past(wr_value[3:0], 2))
        else $error("duplex outputs do not follow write");
    a_half_two_way_clr: assert property (ctrl_r[0] == 1'b0 |=> !o_full_two_way[0])
        else $error("cleared duplex bit left port full duplex");
    a_sleep_follow: assert property (!all_down_r && ctrl_r[11:8] != 4'hF
        |=> o_sleep == $past(ctrl_r[11:8]))
        else $error("sleep outputs do not follow register");
    a_lock_after_all: assert property (ctrl_r[11:8] == 4'hF |=> all_down_r [*3])
        else $error("all-sleep lock not taken or not held");
    a_lock_keeps_sleep: assert property (all_down_r |=> o_sleep == 4'hF)
        else $error("port woke while all-sleep lock held");
endmodule

/* File: mgmt_master_model.sv */
`timescale 1ns/1ps
module mgmt_master_model
    import port_mode_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_dev_mdio,
    input wire logic i_dev_mdio_oe,
    output logic o_mdc,
    output logic o_mdio
);
    logic drv = 1'b1;
    logic drv_oe = 1'b0;

    // wire level: device first, then this master, else the pull-up
    assign o_mdio = i_dev_mdio_oe ? i_dev_mdio : (drv_oe ? drv : 1'b1);

    initial begin
        o_mdc = 1'b0;
    end

    // 4 clocks per half period keeps each mdc phase above the 3-clock sampling floor
    task automatic send_bit(input logic b, output logic s);
        drv = b;
        repeat (4) @(posedge i_clk);
        #1 o_mdc = 1'b1;
        s = o_mdio;
        repeat (4) @(posedge i_clk);
        #1 o_mdc = 1'b0;
    endtask

    // full preamble every frame: no suppression is supported
    task automatic frame(input logic [1:0] op, input logic [4:0] phy, input logic [4:0] reg_a,
                         input logic [15:0] wd, output logic [15:0] rd, output logic ta2);
        logic [13:0] hdr;
        logic s;
        hdr = {2'b01, op, phy, reg_a};
        drv_oe = 1'b1;
        for (int i = 0; i < PREAMBLE_BITS; i++) send_bit(1'b1, s);
        for (int i = 13; i >= 0; i--) send_bit(hdr[i], s);
        drv_oe = (op != OP_READ);
        send_bit(1'b1, s);
        send_bit(1'b0, ta2);
        for (int i = 15; i >= 0; i--) begin
            send_bit(wd[i], s);
            rd[i] = s;
        end
        drv_oe = 1'b0;
        repeat (8) @(posedge i_clk);
        #1;
    endtask
endmodule

/* File: four_port_phy_mode_control_test.sv */
`timescale 1ns/1ps
module four_port_phy_mode_control_test
    import port_mode_pkg::*;
();
    logic i_clk;
    logic i_rst;
    logic mdc, mdio_wire, dev_mdio, dev_mdio_oe, ta2;
    logic [15:0] rd;
    logic [3:0] txd, txen, rxd_core, rxclk_core, col_core;
    logic [3:0] tx_d, tx_en, rxd, rxd_oe, rxclk, rxclk_oe, col, col_oe;
    logic [3:0] self_ret, sleep, rel, full;
    int n_errors = 0;
    int checked = 0;

    typedef struct packed {
        logic [4:0] phy;
        logic [15:0] val;
        logic [3:0] self_ret;
        logic [3:0] sleep;
        logic [3:0] rel;
        logic [3:0] full;
    } row_t;

    row_t rows [7] = '{
        '{5'h00, 16'h8421, 4'h8, 4'h4, 4'h2, 4'h1},
        '{5'h01, 16'h1842, 4'h1, 4'h8, 4'h4, 4'h2},
        '{5'h02, 16'h2184, 4'h2, 4'h1, 4'h8, 4'h4},
        '{5'h03, 16'h4218, 4'h4, 4'h2, 4'h1, 4'h8},
        '{5'h00, 16'hF0FF, 4'hF, 4'h0, 4'hF, 4'hF},
        '{5'h01, 16'h0700, 4'h0, 4'h7, 4'h0, 4'h0},
        '{5'h02, 16'h0000, 4'h0, 4'h0, 4'h0, 4'h0}
    };

    mgmt_master_model u_master (.i_clk(i_clk), .i_dev_mdio(dev_mdio),
        .i_dev_mdio_oe(dev_mdio_oe), .o_mdc(mdc), .o_mdio(mdio_wire));

    port_mode_ctrl u_dut (.i_clk(i_clk), .i_rst(i_rst), .i_mdc(mdc), .i_mdio(mdio_wire),
        .o_mdio(dev_mdio), .o_mdio_oe(dev_mdio_oe), .i_txd(txd), .i_txen(txen),
        .i_rxd_core(rxd_core), .i_rxclk_core(rxclk_core), .i_col_core(col_core),
        .o_tx_d(tx_d), .o_tx_en(tx_en), .o_rxd(rxd), .o_rxd_oe(rxd_oe), .o_rxclk(rxclk),
        .o_rxclk_oe(rxclk_oe), .o_col(col), .o_col_oe(col_oe), .o_self_return(self_ret),
        .o_sleep(sleep), .o_pin_release(rel), .o_full_two_way(full));

    initial begin
        i_clk = 1'b0;
        forever #2.5 i_clk = ~i_clk;
    end

    task automatic test_done();
        $display("comparisons %0d, mismatches %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // tx of a port in plain self-return and the rx clock and collision pins of a released awake port are left open
    task automatic check_pins(input logic [3:0] sl, input logic [3:0] rl, input logic [3:0] lb);
        logic [3:0] mt;
        logic [3:0] mr;
        mt = ~(lb & ~sl & ~rl);
        mr = ~rl | sl;
        check({12'h000, tx_en & mt}, {12'h000, ~sl & ~rl & mt});
        check({12'h000, tx_d & mt}, {12'h000, ~sl & ~rl & mt & txd});
        check({4'h0, rxd_oe, rxclk_oe, col_oe}, {4'h0, ~rl, ~rl, ~rl});
        check({12'h000, rxd}, {12'h000, ~sl & ~rl & lb});
        check({8'h00, col & mr, rxclk & mr}, {8'h00, ~sl & ~lb & mr, ~sl & mr});
    endtask

    task automatic do_reset();
        @(posedge i_clk);
        #1 i_rst = 1'b1;
        repeat (5) @(posedge i_clk);
        #1 i_rst = 1'b0;
        repeat (3) @(posedge i_clk);
        #1;
    endtask

    initial begin
        #200000;
        n_errors++;
        $display("watchdog expired");
        test_done();
    end

    initial begin
        i_rst = 1'b1;
        txd = 4'hF;
        txen = 4'hF;
        rxd_core = 4'h0;
        rxclk_core = 4'hF;
        col_core = 4'hF;
        do_reset();
        check({dev_mdio, dev_mdio_oe, 14'h0000}, 16'h8000);
        check({self_ret, sleep, rel, full}, MODE_CTRL_RESET);
        check_pins(4'h0, 4'h0, 4'h0);
        u_master.frame(OP_READ, 5'h00, MODE_CTRL_ADDR, 16'h0000, rd, ta2);
        check(rd, MODE_CTRL_RESET);
        // different patterns on data and enable so a swapped path shows up
        txen = 4'h5;
        txd = 4'hA;
        repeat (5) @(posedge i_clk);
        #1;
        check({12'h000, tx_en}, 16'h0005);
        check({12'h000, tx_d}, 16'h000A);
        txen = 4'hF;
        txd = 4'hF;
        $display("reset test done");
        foreach (rows[i]) begin
            u_master.frame(OP_WRITE, rows[i].phy, MODE_CTRL_ADDR, rows[i].val, rd, ta2);
            check({self_ret, sleep, rel, full},
                  {rows[i].self_ret, rows[i].sleep, rows[i].rel, rows[i].full});
            check_pins(rows[i].sleep, rows[i].rel, rows[i].self_ret);
            u_master.frame(OP_READ, rows[i].phy, MODE_CTRL_ADDR, 16'h0000, rd, ta2);
            check({15'h0000, ta2}, 16'h0000);
            check(rd, rows[i].val);
        end
        $display("row test done");
        u_master.frame(OP_WRITE, 5'h04, MODE_CTRL_ADDR, 16'hFFFF, rd, ta2);
        u_master.frame(OP_WRITE, 5'h01, 5'h12, 16'hFFFF, rd, ta2);
        check({self_ret, sleep, rel, full}, 16'h0000);
        u_master.frame(OP_READ, 5'h00, 5'h12, 16'h0000, rd, ta2);
        check(rd, 16'hFFFF);
        check({15'h0000, ta2}, 16'h0001);
        $display("refusal test done");
        u_master.frame(OP_WRITE, 5'h02, MODE_CTRL_ADDR, 16'h0F00, rd, ta2);
        check({12'h000, sleep}, 16'h000F);
        u_master.frame(OP_WRITE, 5'h03, MODE_CTRL_ADDR, 16'h0E01, rd, ta2);
        check({12'h000, sleep}, 16'h000F);
        check({12'h000, full}, 16'h0001);
        check_pins(4'hF, 4'h0, 4'h0);
        u_master.frame(OP_READ, 5'h03, MODE_CTRL_ADDR, 16'h0000, rd, ta2);
        check(rd, 16'h0E01);
        // the controller must reset to leave the all-asleep state
        do_reset();
        check({self_ret, sleep, rel, full}, 16'h0000);
        check_pins(4'h0, 4'h0, 4'h0);
        $display("sleep lock test done");
        test_done();
    end
endmodule
